// [design/sdifd_event.sv]
`timescale 1ns/1ps
`default_nettype none

module sdifd_event (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Trigger levels and program tables
  input wire logic [sdifd_pkg::NUM_EV-1:0] ev_lvl,
  input wire logic [sdifd_pkg::EV_CFG_W-1:0] rise_cfg,
  input wire logic [sdifd_pkg::EV_CFG_W-1:0] fall_cfg,
  // Launch request
  output logic launch,
  output logic [5:0] launch_prog
);

  // ==========================================================
  // Edge pick, lowest trigger first, rising before falling
  // ==========================================================
  logic [sdifd_pkg::NUM_EV-1:0] prev_reg;
  logic launch_reg;
  logic [5:0] prog_reg;
  logic hit;
  logic [3:0] nib;

  function automatic logic nib_ok(input logic [3:0] n);
    return n >= sdifd_pkg::EV_NIB_MIN && n <= sdifd_pkg::EV_NIB_MAX;
  endfunction

  always_comb begin
    hit = 1'b0;
    nib = 4'h0;
    for (int i = sdifd_pkg::NUM_EV - 1; i >= 0; i--) begin
      if (!ev_lvl[i] && prev_reg[i] && nib_ok(fall_cfg[i*4 +: 4])) begin
        hit = 1'b1;
        nib = fall_cfg[i*4 +: 4];
      end
      if (ev_lvl[i] && !prev_reg[i] && nib_ok(rise_cfg[i*4 +: 4])) begin
        hit = 1'b1;
        nib = rise_cfg[i*4 +: 4];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg <= '0;
      launch_reg <= 1'b0;
      prog_reg <= 6'h00;
    end else begin
      prev_reg <= ev_lvl;
      launch_reg <= hit;
      prog_reg <= hit ? sdifd_pkg::PROG_BASE + {2'h0, nib} : 6'h00;
    end
  end

  assign launch = launch_reg;
  assign launch_prog = prog_reg;

endmodule // sdifd_event

`default_nettype wire

// [design/sdifd_pkg.sv]
package sdifd_pkg;

  // ==========================================================
  // Sizes
  // ==========================================================
  localparam int NUM_DIN = 10;
  localparam int CODE_W = 6;
  localparam int CODES_W = NUM_DIN * CODE_W;
  localparam int NUM_EV = 4;
  localparam int EV_CFG_W = NUM_EV * 4;

  // ==========================================================
  // Input function codes
  // ==========================================================
  localparam logic [5:0] FC_ENABLE = 6'h01;
  localparam logic [5:0] FC_FAULT_CLR = 6'h02;
  localparam logic [5:0] FC_P_ONLY = 6'h03;
  localparam logic [5:0] FC_TQ_EXT = 6'h04;
  localparam logic [5:0] FC_TQ_INNER2 = 6'h05;
  localparam logic [5:0] FC_VEL0 = 6'h06;
  localparam logic [5:0] FC_VEL1 = 6'h07;
  localparam logic [5:0] FC_VEL2 = 6'h08;
  localparam logic [5:0] FC_RUN_A = 6'h09;
  localparam logic [5:0] FC_RUN_B = 6'h0A;
  localparam logic [5:0] FC_ORIGIN_CAP = 6'h0B;
  localparam logic [5:0] FC_GO_ORIGIN = 6'h0C;
  localparam logic [5:0] FC_GEAR0 = 6'h0D;
  localparam logic [5:0] FC_GEAR1 = 6'h0E;
  localparam logic [5:0] FC_DROOP_CLR = 6'h0F;
  localparam logic [5:0] FC_GAIN_SWAP = 6'h10;
  localparam logic [5:0] FC_HYBRID = 6'h11;
  localparam logic [5:0] FC_EMERGENCY = 6'h12;
  localparam logic [5:0] FC_TGT0 = 6'h13;
  localparam logic [5:0] FC_TGT1 = 6'h14;
  localparam logic [5:0] FC_TGT2 = 6'h15;
  localparam logic [5:0] FC_TGT_SWITCH = 6'h16;
  localparam logic [5:0] FC_HOLD = 6'h17;
  localparam logic [5:0] FC_FWD_LIMIT = 6'h18;
  localparam logic [5:0] FC_REV_LIMIT = 6'h19;
  localparam logic [5:0] FC_TGT3 = 6'h1A;
  localparam logic [5:0] FC_TGT4 = 6'h1B;
  localparam logic [5:0] FC_EV1 = 6'h1E;
  localparam logic [5:0] FC_EV2 = 6'h1F;
  localparam logic [5:0] FC_EV3 = 6'h20;
  localparam logic [5:0] FC_EV4 = 6'h21;
  localparam logic [5:0] FC_STOP = 6'h24;

  // ==========================================================
  // Modes and selections
  // ==========================================================
  localparam logic [1:0] MODE_POS = 2'h0;
  localparam logic [1:0] MODE_SPEED = 2'h1;
  localparam logic [1:0] MODE_TORQUE = 2'h2;
  localparam logic [1:0] TQ_INNER1 = 2'h0;
  localparam logic [1:0] TQ_EXT = 2'h1;
  localparam logic [1:0] TQ_INNER2 = 2'h2;
  localparam logic [3:0] EV_NIB_MIN = 4'h1;
  localparam logic [3:0] EV_NIB_MAX = 4'hD;
  localparam logic [5:0] PROG_BASE = 6'h32;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 20;
  localparam int DROOP_MIN_NS = 10_000_000;
  localparam int DROOP_MIN_CYCLES =
    (DROOP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DROOP_CNT_W = 20;

  // ==========================================================
  // Function code lookup
  // ==========================================================
  function automatic logic code_hit(input logic [CODES_W-1:0] codes,
                                    input logic [NUM_DIN-1:0] lvl,
                                    input logic [CODE_W-1:0] fc);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DIN; i++) begin
      if (codes[i*CODE_W +: CODE_W] == fc && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

endpackage

// [design/sdifd_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module sdifd_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins and synchronised levels
  input wire logic [sdifd_pkg::NUM_DIN-1:0] pin_async,
  output logic [sdifd_pkg::NUM_DIN-1:0] pin_sync
);

  // ==========================================================
  // Two-stage synchroniser
  // ==========================================================
  logic [sdifd_pkg::NUM_DIN-1:0] meta_reg;
  logic [sdifd_pkg::NUM_DIN-1:0] sync_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;

endmodule // sdifd_sync

`default_nettype wire

// [design/sdifd_top.sv]
// What this block does
// - Input coded 01 active keeps the drive enabled.
// - Input coded 02 activating clears a resettable alarm.
// - Input coded 03 active makes the speed loop proportional only.
// - Input coded 04 active takes torque limit from the analog input.
// - Input coded 05 active makes inner torque limit two effective.
// - Codes 06, 07, 08 form the three speed select bits.
// - Code 09: forward in speed mode, reverse in torque mode.
// - Code 0A: reverse in speed mode, forward in torque mode.
// - Code 0B activating in register position mode captures the origin.
// - Code 0C activating moves the motor back to origin.
// - Codes 0D and 0E select the gear numerator.
// - Code 0F rising edge clears droop; host holds it 10 ms.
// - Code 10 active selects the alternate gain multipliers.
// - Code 11 picks the active mode when hybrid control is set.
// - Code 12 off forces emergency stop; on releases it.
// - Codes 13, 14, 15, 1A, 1B select the position command.
// - Code 16 triggers switching among internal position commands.
// - Codes 17 or 24 stop motion in program position mode.
// - Codes 18 and 19 are forward and reverse travel limits.
// - Codes 1E to 21 are four program event triggers.
// - Trigger nibble zero does nothing; 1 to D launch 51 to 63.
`timescale 1ns/1ps
`default_nettype none

module sdifd_top #(
  parameter int DROOP_MIN_CYCLES = sdifd_pkg::DROOP_MIN_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Input pins and their function codes
  input wire logic [sdifd_pkg::NUM_DIN-1:0] din_pin,
  input wire logic [sdifd_pkg::CODES_W-1:0] din_func_codes,
  // Drive configuration
  input wire logic [1:0] ctrl_mode,
  input wire logic pos_internal_mode,
  input wire logic prog_mode,
  input wire logic hybrid_cfg,
  input wire logic [sdifd_pkg::EV_CFG_W-1:0] ev_rise_cfg,
  input wire logic [sdifd_pkg::EV_CFG_W-1:0] ev_fall_cfg,
  // Drive state requests
  output logic drive_enable,
  output logic fault_clear_pulse,
  output logic p_only_mode,
  output logic [1:0] torque_cap_sel,
  output logic [2:0] velocity_sel,
  output logic run_forward,
  output logic run_reverse,
  output logic gain_alt,
  output logic hybrid_alt,
  output logic emergency_halt,
  // Position requests
  output logic origin_capture_pulse,
  output logic go_origin_pulse,
  output logic [1:0] gear_sel,
  output logic droop_clear_pulse,
  output logic droop_width_err,
  output logic [4:0] target_sel,
  output logic target_switch_pulse,
  output logic motion_hold,
  output logic fwd_limit_hit,
  output logic rev_limit_hit,
  // Program launches
  output logic program_launch,
  output logic [5:0] program_number
);

  // ==========================================================
  // Pin synchronisation
  // ==========================================================
  logic [sdifd_pkg::NUM_DIN-1:0] din_sync;

  sdifd_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_async(din_pin),
    .pin_sync(din_sync)
  );

  // ==========================================================
  // Function decode
  // ==========================================================
  localparam logic [sdifd_pkg::NUM_DIN-1:0] ALL_ON = '1;

  logic drive_enable_input;
  logic fault_clear_input;
  logic p_only_switch;
  logic torque_cap_source;
  logic inner_torque_cap_two;
  logic [2:0] velocity_bits;
  logic run_cmd_a;
  logic run_cmd_b;
  logic origin_capture;
  logic go_to_origin;
  logic [1:0] gear_bits;
  logic droop_clear;
  logic gain_swap;
  logic hybrid_mode_switch;
  logic emergency_halt_input;
  logic emergency_assigned;
  logic [4:0] target_bits;
  logic target_switch;
  logic hold_request;
  logic forward_travel_limit;
  logic reverse_travel_limit;
  logic [sdifd_pkg::NUM_EV-1:0] trigger_lvl;

  function automatic logic dec(input logic [sdifd_pkg::CODE_W-1:0] fc);
    return sdifd_pkg::code_hit(din_func_codes, din_sync, fc);
  endfunction

  // Unknown codes never match a decode term
  always_comb begin
    drive_enable_input = dec(sdifd_pkg::FC_ENABLE);
    fault_clear_input = dec(sdifd_pkg::FC_FAULT_CLR);
    p_only_switch = dec(sdifd_pkg::FC_P_ONLY);
    torque_cap_source = dec(sdifd_pkg::FC_TQ_EXT);
    inner_torque_cap_two = dec(sdifd_pkg::FC_TQ_INNER2);
    velocity_bits[0] = dec(sdifd_pkg::FC_VEL0);
    velocity_bits[1] = dec(sdifd_pkg::FC_VEL1);
    velocity_bits[2] = dec(sdifd_pkg::FC_VEL2);
    run_cmd_a = dec(sdifd_pkg::FC_RUN_A);
    run_cmd_b = dec(sdifd_pkg::FC_RUN_B);
    origin_capture = dec(sdifd_pkg::FC_ORIGIN_CAP);
    go_to_origin = dec(sdifd_pkg::FC_GO_ORIGIN);
    gear_bits[0] = dec(sdifd_pkg::FC_GEAR0);
    gear_bits[1] = dec(sdifd_pkg::FC_GEAR1);
    droop_clear = dec(sdifd_pkg::FC_DROOP_CLR);
    gain_swap = dec(sdifd_pkg::FC_GAIN_SWAP);
    hybrid_mode_switch = dec(sdifd_pkg::FC_HYBRID);
    emergency_halt_input = dec(sdifd_pkg::FC_EMERGENCY);
    emergency_assigned = sdifd_pkg::code_hit(din_func_codes, ALL_ON,
      sdifd_pkg::FC_EMERGENCY);
    target_bits[0] = dec(sdifd_pkg::FC_TGT0);
    target_bits[1] = dec(sdifd_pkg::FC_TGT1);
    target_bits[2] = dec(sdifd_pkg::FC_TGT2);
    target_bits[3] = dec(sdifd_pkg::FC_TGT3);
    target_bits[4] = dec(sdifd_pkg::FC_TGT4);
    target_switch = dec(sdifd_pkg::FC_TGT_SWITCH);
    hold_request = dec(sdifd_pkg::FC_HOLD) | dec(sdifd_pkg::FC_STOP);
    forward_travel_limit = dec(sdifd_pkg::FC_FWD_LIMIT);
    reverse_travel_limit = dec(sdifd_pkg::FC_REV_LIMIT);
    trigger_lvl[0] = dec(sdifd_pkg::FC_EV1);
    trigger_lvl[1] = dec(sdifd_pkg::FC_EV2);
    trigger_lvl[2] = dec(sdifd_pkg::FC_EV3);
    trigger_lvl[3] = dec(sdifd_pkg::FC_EV4);
  end

  // ==========================================================
  // Edge history for pulsed functions
  // ==========================================================
  logic [4:0] prev_reg;
  logic [4:0] edge_lvl;
  logic [4:0] rise;

  assign edge_lvl = {target_switch, droop_clear, go_to_origin,
                     origin_capture, fault_clear_input};
  assign rise = edge_lvl & ~prev_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg <= 5'h00;
    end else begin
      prev_reg <= edge_lvl;
    end
  end

  // ==========================================================
  // Drive state levels
  // ==========================================================
  logic enable_reg;
  logic p_only_reg;
  logic [1:0] torque_reg;
  logic [2:0] velocity_reg;
  logic gain_reg;
  logic hybrid_reg;
  logic halt_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_reg <= 1'b0;
      p_only_reg <= 1'b0;
      velocity_reg <= 3'h0;
      gain_reg <= 1'b0;
      hybrid_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      enable_reg <= drive_enable_input;
      p_only_reg <= p_only_switch;
      velocity_reg <= velocity_bits;
      gain_reg <= gain_swap;
      hybrid_reg <= hybrid_cfg & hybrid_mode_switch;
      // Halt only when an input carries the emergency code
      halt_reg <= emergency_assigned & ~emergency_halt_input;
    end
  end

  // Inner limit two outranks the analog source
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      torque_reg <= sdifd_pkg::TQ_INNER1;
    end else if (inner_torque_cap_two) begin
      torque_reg <= sdifd_pkg::TQ_INNER2;
    end else if (torque_cap_source) begin
      torque_reg <= sdifd_pkg::TQ_EXT;
    end else begin
      torque_reg <= sdifd_pkg::TQ_INNER1;
    end
  end

  // ==========================================================
  // Run direction
  // ==========================================================
  logic fwd_reg;
  logic rev_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fwd_reg <= 1'b0;
      rev_reg <= 1'b0;
    end else if (ctrl_mode == sdifd_pkg::MODE_SPEED) begin
      fwd_reg <= run_cmd_a & ~run_cmd_b;
      rev_reg <= run_cmd_b & ~run_cmd_a;
    end else if (ctrl_mode == sdifd_pkg::MODE_TORQUE) begin
      fwd_reg <= run_cmd_b & ~run_cmd_a;
      rev_reg <= run_cmd_a & ~run_cmd_b;
    end else begin
      fwd_reg <= 1'b0;
      rev_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Pulsed requests
  // ==========================================================
  logic fault_clr_reg;
  logic origin_cap_reg;
  logic go_origin_reg;
  logic droop_reg;
  logic tgt_switch_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_clr_reg <= 1'b0;
      origin_cap_reg <= 1'b0;
      go_origin_reg <= 1'b0;
      droop_reg <= 1'b0;
      tgt_switch_reg <= 1'b0;
    end else begin
      fault_clr_reg <= rise[0];
      origin_cap_reg <= rise[1] & pos_internal_mode;
      go_origin_reg <= rise[2];
      droop_reg <= rise[3];
      tgt_switch_reg <= rise[4];
    end
  end

  // ==========================================================
  // Droop clear width check
  // ==========================================================
  localparam logic [sdifd_pkg::DROOP_CNT_W-1:0] DROOP_MIN =
    sdifd_pkg::DROOP_CNT_W'(DROOP_MIN_CYCLES);

  logic [sdifd_pkg::DROOP_CNT_W-1:0] droop_cnt_reg;
  logic droop_err_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      droop_cnt_reg <= '0;
    end else if (!droop_clear) begin
      droop_cnt_reg <= '0;
    end else if (droop_cnt_reg < DROOP_MIN) begin
      droop_cnt_reg <= droop_cnt_reg + 1'b1;
    end
  end

  // Flags a clear pulse released before its minimum width
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      droop_err_reg <= 1'b0;
    end else begin
      droop_err_reg <= prev_reg[3] & ~droop_clear &
                       (droop_cnt_reg < DROOP_MIN);
    end
  end

  // ==========================================================
  // Position selection and motion gating
  // ==========================================================
  logic [1:0] gear_reg;
  logic [4:0] target_reg;
  logic hold_reg;
  logic fwd_lim_reg;
  logic rev_lim_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gear_reg <= 2'h0;
      target_reg <= 5'h00;
    end else begin
      gear_reg <= gear_bits;
      target_reg <= target_bits;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= prog_mode & hold_request;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fwd_lim_reg <= 1'b0;
      rev_lim_reg <= 1'b0;
    end else begin
      fwd_lim_reg <= forward_travel_limit;
      rev_lim_reg <= reverse_travel_limit;
    end
  end

  // ==========================================================
  // Event triggered programs
  // ==========================================================
  sdifd_event u_event (
    .clk(clk),
    .sys_rst(sys_rst),
    .ev_lvl(trigger_lvl),
    .rise_cfg(ev_rise_cfg),
    .fall_cfg(ev_fall_cfg),
    .launch(program_launch),
    .launch_prog(program_number)
  );

  // ==========================================================
  // Outputs
  // ==========================================================
  assign drive_enable = enable_reg;
  assign fault_clear_pulse = fault_clr_reg;
  assign p_only_mode = p_only_reg;
  assign torque_cap_sel = torque_reg;
  assign velocity_sel = velocity_reg;
  assign run_forward = fwd_reg;
  assign run_reverse = rev_reg;
  assign gain_alt = gain_reg;
  assign hybrid_alt = hybrid_reg;
  assign emergency_halt = halt_reg;
  assign origin_capture_pulse = origin_cap_reg;
  assign go_origin_pulse = go_origin_reg;
  assign gear_sel = gear_reg;
  assign droop_clear_pulse = droop_reg;
  assign droop_width_err = droop_err_reg;
  assign target_sel = target_reg;
  assign target_switch_pulse = tgt_switch_reg;
  assign motion_hold = hold_reg;
  assign fwd_limit_hit = fwd_lim_reg;
  assign rev_limit_hit = rev_lim_reg;

endmodule // sdifd_top

`default_nettype wire

// [verification/sdifd_host.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host pin driver
// ==========================================================
module sdifd_host (
  // Clock
  input wire logic clk,
  // Pin levels
  output logic [9:0] din_pin
);
  initial din_pin = 10'h000;

  // New pin levels just after an edge
  task automatic put(input logic [9:0] p);
    @(posedge clk);
    din_pin <= p;
  endtask

  // Clear pulse on pin i held n cycles
  task automatic droop(input int i, input int n);
    put(din_pin | (10'h001 << i));
    repeat (n - 1) @(posedge clk);
    put(din_pin & ~(10'h001 << i));
  endtask
endmodule // sdifd_host

`default_nettype wire

// [verification/sdifd_properties.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Request checker
// ==========================================================
module sdifd_properties #(
  parameter int DROOP_MIN_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration
  input wire logic [1:0] ctrl_mode,
  input wire logic pos_internal_mode,
  input wire logic prog_mode,
  input wire logic hybrid_cfg,
  // Requests
  input wire logic fault_clear_pulse,
  input wire logic [1:0] torque_cap_sel,
  input wire logic run_forward,
  input wire logic run_reverse,
  input wire logic hybrid_alt,
  input wire logic origin_capture_pulse,
  input wire logic droop_clear_pulse,
  input wire logic droop_width_err,
  input wire logic motion_hold,
  input wire logic program_launch,
  input wire logic [5:0] program_number
);
  logic [19:0] since_clr_reg;

  // Cycles since the last droop clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_clr_reg <= '1;
    end else if (droop_clear_pulse) begin
      since_clr_reg <= '0;
    end else if (since_clr_reg != '1) begin
      since_clr_reg <= since_clr_reg + 20'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_drop(p);
    ##1 !p;
  endsequence
  property p_once(p);
    p |-> s_drop(p);
  endproperty

  fault_pulse_a: assert property (p_once(fault_clear_pulse))
    else $error("fault clear pulse too long");
  droop_pulse_a: assert property (p_once(droop_clear_pulse))
    else $error("droop clear pulse too long");
  droop_width_a: assert property (droop_width_err |->
    since_clr_reg < DROOP_MIN_CYCLES) else $error("droop width flag wrong");
  origin_gate_a: assert property (origin_capture_pulse |->
    $past(pos_internal_mode)) else $error("origin capture not gated");
  launch_range_a: assert property (program_launch |->
    program_number inside {[6'h33:6'h3F]}) else $error("bad program");
  launch_idle_a: assert property (!program_launch |->
    program_number == 6'h00) else $error("program number without launch");
  torque_sel_a: assert property (torque_cap_sel != 2'h3)
    else $error("torque selection out of range");
  direction_a: assert property ((run_forward || run_reverse) |->
    !(run_forward && run_reverse) && $past(ctrl_mode) inside {2'h1, 2'h2})
    else $error("direction request wrong");
  hybrid_gate_a: assert property (hybrid_alt |-> $past(hybrid_cfg))
    else $error("hybrid switch not gated");
  hold_gate_a: assert property (motion_hold |-> $past(prog_mode))
    else $error("hold not gated by program mode");
endmodule // sdifd_properties

bind sdifd_top sdifd_properties #(.DROOP_MIN_CYCLES(DROOP_MIN_CYCLES)) chk_u (
  .clk, .sys_rst, .ctrl_mode, .pos_internal_mode, .prog_mode, .hybrid_cfg,
  .fault_clear_pulse, .torque_cap_sel, .run_forward, .run_reverse,
  .hybrid_alt, .origin_capture_pulse, .droop_clear_pulse, .droop_width_err,
  .motion_hold, .program_launch, .program_number);

`default_nettype wire

// [verification/servo_digital_input_function_decoder_test.sv]
`timescale 1ns/1ps
`default_nettype none

module servo_digital_input_function_decoder_test;
  localparam int DROOP = 20;
  localparam logic [15:0] RISE = 16'hD951;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [59:0] din_func_codes = {10{6'h3F}};
  logic [1:0] ctrl_mode = 2'h1;
  logic pos_internal_mode = 1'b1, prog_mode = 1'b1, hybrid_cfg = 1'b1;
  logic [15:0] ev_rise_cfg = 16'h0000, ev_fall_cfg = 16'h0000;
  logic [9:0] din_pin;
  logic drive_enable, fault_clear_pulse, p_only_mode, run_forward;
  logic run_reverse, gain_alt, hybrid_alt, emergency_halt, motion_hold;
  logic origin_capture_pulse, go_origin_pulse, droop_clear_pulse;
  logic droop_width_err, target_switch_pulse, fwd_limit_hit;
  logic rev_limit_hit, program_launch;
  logic [1:0] torque_cap_sel, gear_sel;
  logic [2:0] velocity_sel;
  logic [4:0] target_sel;
  logic [5:0] program_number, prog;
  logic [6:0] seen;
  int bad_count = 0, checked = 0;
  logic [5:0] tc [29] = '{6'h01, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
    6'h09, 6'h0A, 6'h10, 6'h11, 6'h0D, 6'h0E, 6'h13, 6'h14, 6'h15, 6'h1A,
    6'h1B, 6'h17, 6'h24, 6'h18, 6'h19, 6'h02, 6'h0B, 6'h0C, 6'h16, 6'h1C,
    6'h22, 6'h3F};
  logic [28:0] te [29] = '{29'h200000, 29'h100000, 29'h40000, 29'h80000,
    29'h8000, 29'h10000, 29'h20000, 29'h4000, 29'h2000, 29'h1000, 29'h800,
    29'h100, 29'h200, 29'h8, 29'h10, 29'h20, 29'h40, 29'h80, 29'h4, 29'h4,
    29'h2, 29'h1, 29'h400000, 29'h800000, 29'h1000000, 29'h4000000, 29'h0,
    29'h0, 29'h0};

  initial begin
    forever #10 clk = ~clk;
  end

  sdifd_host host_u (.clk, .din_pin);

  sdifd_top #(.DROOP_MIN_CYCLES(DROOP)) dut_u (.clk, .sys_rst, .din_pin,
    .din_func_codes, .ctrl_mode, .pos_internal_mode, .prog_mode, .hybrid_cfg,
    .ev_rise_cfg, .ev_fall_cfg, .drive_enable, .fault_clear_pulse,
    .p_only_mode, .torque_cap_sel, .velocity_sel, .run_forward, .run_reverse,
    .gain_alt, .hybrid_alt, .emergency_halt, .origin_capture_pulse,
    .go_origin_pulse, .gear_sel, .droop_clear_pulse, .droop_width_err,
    .target_sel, .target_switch_pulse, .motion_hold, .fwd_limit_hit,
    .rev_limit_hit, .program_launch, .program_number);

  // ==========================================================
  // Pulse capture
  // ==========================================================
  always @(posedge clk) begin
    seen <= seen | {droop_width_err, program_launch, target_switch_pulse,
      droop_clear_pulse, go_origin_pulse, origin_capture_pulse,
      fault_clear_pulse};
    if (program_launch) begin
      prog <= program_number;
    end
  end

  function automatic logic [21:0] obs();
    return {drive_enable, p_only_mode, torque_cap_sel, velocity_sel,
      run_forward, run_reverse, gain_alt, hybrid_alt, emergency_halt,
      gear_sel, target_sel, motion_hold, fwd_limit_hit, rev_limit_hit};
  endfunction

  function automatic logic [59:0] f1(input logic [5:0] c);
    return {{9{6'h3F}}, c};
  endfunction

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic go(input logic [59:0] c, input logic [9:0] p);
    @(negedge clk) seen = 7'h00;
    @(posedge clk) din_func_codes <= c;
    host_u.put(p);
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic dr(input int n, input logic [6:0] exp);
    @(negedge clk) seen = 7'h00;
    host_u.droop(0, n);
    repeat (4) @(posedge clk);
    @(negedge clk) chk(seen, exp);
  endtask

  task automatic stop_test();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #1ms bad_count++;
    stop_test();
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    seen = 7'h00;
    repeat (19) @(posedge clk);
    @(negedge clk) chk({obs(), program_number}, 32'h0);
    @(posedge clk) sys_rst <= 1'b0;
    for (int i = 0; i < 29; i++) begin
      go(f1(tc[i]), 10'h001);
      chk({seen, obs()}, te[i]);
      go(f1(tc[i]), 10'h000);
      chk({seen, obs()}, 32'h0);
    end
    @(posedge clk) ctrl_mode <= 2'h2;
    go(f1(6'h09), 10'h001);
    chk(obs(), 32'h2000);
    go(f1(6'h0A), 10'h001);
    chk(obs(), 32'h4000);
    go(f1(6'h12), 10'h001);
    chk(obs(), 32'h0);
    go(f1(6'h12), 10'h000);
    chk(obs(), 32'h400);
    go({6'h1B, 6'h1A, 6'h15, 6'h14, 6'h13, 6'h0E, 6'h0D, 6'h08, 6'h07, 6'h06},
      10'h2A5);
    chk(obs(), 32'h280A8);
    @(posedge clk) {ctrl_mode, pos_internal_mode, prog_mode, hybrid_cfg} <=
      5'h00;
    foreach (tc[i]) if (tc[i] inside {6'h0B, 6'h11, 6'h17, 6'h09}) begin
      go(f1(tc[i]), 10'h001);
      chk({seen, obs()}, 32'h0);
      go(f1(tc[i]), 10'h000);
    end
    go(f1(6'h0F), 10'h000);
    dr(DROOP - 1, 7'h48);
    dr(DROOP, 7'h08);
    @(posedge clk) {ev_rise_cfg, ev_fall_cfg} <= {RISE, 16'h70E0};
    for (int k = 0; k < 4; k++) begin
      go(f1(6'h1E + 6'(k)), 10'h001);
      chk({seen, prog}, {7'h20, 6'h32 + {2'h0, RISE[4*k +: 4]}});
      go(f1(6'h1E + 6'(k)), 10'h000);
      chk(seen, (k == 3) ? 7'h20 : 7'h00);
    end
    chk(prog, 6'h39);
    stop_test();
  end
endmodule // servo_digital_input_function_decoder_test

`default_nettype wire
